// ==== src/sleep_port_clock_gating.sv ====
`include "port_gate_defines.svh"

module sleep_port_clock_gating #(
  parameter int NUM_PORTS = `NUM_PORTS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [`APB_DATA_W-1:0] pwdata,
  output logic [`APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_PORTS-1:0] run_port_clock_gate,
  input wire logic [NUM_PORTS-1:0] deep_sleep_port_clock_gate,
  input wire logic auto_gating_select,
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire port_gate_pkg::port_access_t port_access,
  output logic [NUM_PORTS-1:0] port_clk_en,
  output logic port_fault,
  output logic irq
);

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic logic [NUM_PORTS-1:0] port_onehot(
    input logic [`PORT_SEL_W-1:0] p
  );
    port_onehot = '0;
    port_onehot[p] = 1'b1;
  endfunction

  function automatic logic [`APB_DATA_W-1:0] widen(
    input logic [NUM_PORTS-1:0] v
  );
    widen = '0;
    widen[NUM_PORTS-1:0] = v;
  endfunction

  logic setup;
  logic wr_done;
  logic [NUM_PORTS-1:0] wr_bits;

  assign setup = psel & ~penable & ~pready;
  assign wr_done = psel & penable & pready & pwrite;
  assign wr_bits = pwdata[NUM_PORTS-1:0];

  // Power mode tracking.
  port_gate_pkg::power_mode_t mode_r;
  port_gate_pkg::power_mode_t mode_nxt;
  logic [NUM_PORTS-1:0] gate_sel;
  logic [NUM_PORTS-1:0] sleep_gate_r;
  logic [NUM_PORTS-1:0] sleep_gate_nxt;

  always_comb begin
    if (deep_sleep_req) begin
      mode_nxt = port_gate_pkg::MODE_DEEP;
    end else if (sleep_req) begin
      mode_nxt = port_gate_pkg::MODE_SLEEP;
    end else begin
      mode_nxt = port_gate_pkg::MODE_RUN;
    end
    gate_sel = run_port_clock_gate;
    case (mode_r)
      port_gate_pkg::MODE_RUN: begin
        gate_sel = run_port_clock_gate;
      end
      port_gate_pkg::MODE_SLEEP: begin
        if (auto_gating_select) begin
          gate_sel = sleep_gate_r;
        end
      end
      port_gate_pkg::MODE_DEEP: begin
        if (auto_gating_select) begin
          gate_sel = deep_sleep_port_clock_gate;
        end
      end
      default: begin
        gate_sel = run_port_clock_gate;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= port_gate_pkg::MODE_RUN;
    end else if (ce) begin
      mode_r <= mode_nxt;
    end
  end

  clock_enable_stage #(
    .NUM_PORTS(NUM_PORTS)
  ) u_enable_stage (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .enable_sel(gate_sel),
    .enable_r(port_clk_en)
  );

  reset_zero_a: assert property (
    $rose(presetn) |-> sleep_gate_r == '0 && port_clk_en == '0)
    else $error("Gating state not zero after reset.");

  deep_wins_a: assert property (
    ce && deep_sleep_req |=> mode_r == port_gate_pkg::MODE_DEEP)
    else $error("Deep sleep request did not win over sleep.");

  sleep_select_a: assert property (
    ce && mode_r == port_gate_pkg::MODE_SLEEP && auto_gating_select
      |=> port_clk_en == $past(sleep_gate_r))
    else $error("Sleep mode did not use the sleep gating set.");

  deep_select_a: assert property (
    ce && mode_r == port_gate_pkg::MODE_DEEP && auto_gating_select
      |=> port_clk_en == $past(deep_sleep_port_clock_gate))
    else $error("Deep sleep did not use the deep sleep set.");

  no_auto_run_a: assert property (
    ce && !auto_gating_select
      |=> port_clk_en == $past(run_port_clock_gate))
    else $error("Without auto gating the run set must apply.");

  enable_clock_a: assert property (
    ce && mode_r == port_gate_pkg::MODE_SLEEP && auto_gating_select
      && sleep_gate_r[0] ##1 ce |=> port_clk_en[0] == $past(gate_sel[0]))
    else $error("Port enable did not track its bit.");

  // Fault detection and interrupt state.
  logic [NUM_PORTS-1:0] fault_set;
  logic [NUM_PORTS-1:0] fault_status_r;
  logic [NUM_PORTS-1:0] fault_status_nxt;
  logic [NUM_PORTS-1:0] fault_mask_r;
  logic [NUM_PORTS-1:0] fault_mask_nxt;
  logic port_fault_nxt;
  logic irq_nxt;

  always_comb begin
    fault_set = '0;
    if (port_access.valid && !port_clk_en[port_access.port]) begin
      fault_set = port_onehot(port_access.port);
    end
    port_fault_nxt = |fault_set;
    sleep_gate_nxt = sleep_gate_r;
    fault_mask_nxt = fault_mask_r;
    fault_status_nxt = fault_status_r;
    if (wr_done) begin
      case (paddr)
        `SLEEP_GATE_OFS: begin
          sleep_gate_nxt = wr_bits;
        end
        `FAULT_MASK_OFS: begin
          fault_mask_nxt = wr_bits;
        end
        `FAULT_STATUS_OFS: begin
          fault_status_nxt = fault_status_r & ~wr_bits;
        end
        default: begin
          sleep_gate_nxt = sleep_gate_r;
        end
      endcase
    end
    // A new fault wins over a clear in the same cycle.
    fault_status_nxt = fault_status_nxt | fault_set;
    irq_nxt = |(fault_status_nxt & fault_mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_gate_r <= `SLEEP_GATE_RESET;
      fault_status_r <= `FAULT_STATUS_RESET;
      fault_mask_r <= `FAULT_MASK_RESET;
      port_fault <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      sleep_gate_r <= sleep_gate_nxt;
      fault_status_r <= fault_status_nxt;
      fault_mask_r <= fault_mask_nxt;
      port_fault <= port_fault_nxt;
      irq <= irq_nxt;
    end
  end

  gated_fault_a: assert property (
    ce && port_access.valid && !port_clk_en[port_access.port]
      |=> port_fault && fault_status_r[$past(port_access.port)])
    else $error("Access to gated port raised no fault.");

  clocked_ok_a: assert property (
    ce && !(port_access.valid && !port_clk_en[port_access.port])
      |=> !port_fault)
    else $error("Fault raised for a clocked port.");

  status_sticky_a: assert property (
    ce && !(wr_done && paddr == `FAULT_STATUS_OFS)
      |=> (fault_status_r & $past(fault_status_r)) == $past(fault_status_r))
    else $error("Fault status bit dropped without a clear.");

  fault_clear_a: assert property (
    ce && wr_done && paddr == `FAULT_STATUS_OFS && fault_set == '0
      |=> (fault_status_r & $past(wr_bits)) == '0)
    else $error("Writing a one did not clear the fault status bit.");

  irq_level_a: assert property (
    irq == |(fault_status_r & fault_mask_r))
    else $error("Interrupt level does not match the masked status.");

  // Bus answer, one access cycle with pready high.
  logic [`APB_DATA_W-1:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;

  always_comb begin
    pready_nxt = setup;
    pslverr_nxt = 1'b0;
    prdata_nxt = '0;
    if (setup) begin
      case (paddr)
        `SLEEP_GATE_OFS: begin
          prdata_nxt = widen(sleep_gate_r);
        end
        `FAULT_STATUS_OFS: begin
          prdata_nxt = widen(fault_status_r);
        end
        `FAULT_MASK_OFS: begin
          prdata_nxt = widen(fault_mask_r);
        end
        `ACTIVE_GATE_OFS: begin
          prdata_nxt = widen(port_clk_en);
          pslverr_nxt = pwrite;
        end
        default: begin
          pslverr_nxt = 1'b1;
        end
      endcase
      if (pwrite) begin
        prdata_nxt = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  sequence gate_write_s;
    ce && psel && penable && pready && pwrite && paddr == `SLEEP_GATE_OFS;
  endsequence

  sequence gate_read_s;
    ce && psel && !penable && !pready && !pwrite
      && paddr == `SLEEP_GATE_OFS ##1 pready;
  endsequence

  gate_write_a: assert property (
    gate_write_s |=> sleep_gate_r == $past(wr_bits))
    else $error("Sleep gating write did not take effect.");

  reserved_read_a: assert property (
    gate_read_s |-> prdata[`APB_DATA_W-1:NUM_PORTS] == '0
      && prdata[NUM_PORTS-1:0] == sleep_gate_r && !pslverr)
    else $error("Sleep gating read returned wrong data.");

  ro_write_a: assert property (
    ce && setup && pwrite && paddr == `ACTIVE_GATE_OFS |=> pready && pslverr)
    else $error("Write to the active enable view was not refused.");

  bus_reset_a: assert property (
    $rose(presetn) |-> !pready && !pslverr && !port_fault && !irq
      && prdata == '0)
    else $error("Bus outputs not idle after reset.");

endmodule // sleep_port_clock_gating

// ==== src/port_gate_defines.svh ====
`ifndef PORT_GATE_DEFINES_SVH
`define PORT_GATE_DEFINES_SVH

`define SYSCTL_BASE 32'h400f_e000
`define NUM_PORTS 8
`define PORT_SEL_W 3
`define APB_ADDR_W 12
`define APB_DATA_W 32

`define SLEEP_GATE_OFS 12'h118
`define FAULT_STATUS_OFS 12'h200
`define FAULT_MASK_OFS 12'h204
`define ACTIVE_GATE_OFS 12'h208

`define SLEEP_GATE_RESET 8'h00
`define FAULT_STATUS_RESET 8'h00
`define FAULT_MASK_RESET 8'h00

`endif

// ==== src/port_gate_pkg.sv ====
`include "port_gate_defines.svh"

package port_gate_pkg;

  typedef enum logic [2:0] {
    MODE_RUN = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_DEEP = 3'b100
  } power_mode_t;

  typedef struct packed {
    logic valid;
    logic [`PORT_SEL_W-1:0] port;
  } port_access_t;

endpackage

// ==== src/clock_enable_stage.sv ====
module clock_enable_stage #(
  parameter int NUM_PORTS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [NUM_PORTS-1:0] enable_sel,
  output logic [NUM_PORTS-1:0] enable_r
);

  logic [NUM_PORTS-1:0] enable_nxt;

  always_comb begin
    enable_nxt = enable_sel;
  end

  // Enables change only at a rising edge or when presetn clears them, so a downstream gate sees no glitch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= '0;
    end else if (ce) begin
      enable_r <= enable_nxt;
    end
  end

  enable_frozen_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(enable_r))
    else $error("Clock enables moved while clock enable was low.");

  enable_follow_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce |=> enable_r == $past(enable_sel))
    else $error("Clock enables did not follow the selected set.");

endmodule // clock_enable_stage

// ==== verif/gpio_port_model.sv ====
// Stand-in for the port modules: issues one bus access per request.
module gpio_port_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [2:0] sel,
  output port_gate_pkg::port_access_t port_access
);
  timeunit 1ns;
  timeprecision 1ps;
  port_gate_pkg::port_access_t acc_nxt;

  always_comb begin
    acc_nxt.valid = go;
    acc_nxt.port = sel;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_access <= '0;
    end else begin
      port_access <= acc_nxt;
    end
  end
endmodule // gpio_port_model

// ==== verif/tb_sleep_port_clock_gating.sv ====
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_sleep_port_clock_gating;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } row_t;
  row_t rows[3] = '{'{12'h118, 32'hffff_ffa5, 32'h0000_00a5, 1'b0},
    '{12'h204, 32'h0000_000f, 32'h0000_000f, 1'b0},
    '{12'h300, 32'hffff_ffff, 32'h0000_0000, 1'b1}};
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, auto = 0, slp = 0, deep = 0, go = 0, f;
  logic [7:0] run_set = '0, deep_set = '0, port_clk_en;
  logic [2:0] sel = '0;
  logic port_fault, irq;
  port_gate_pkg::port_access_t port_access;
  int error_cnt = 0, check_count = 0;

  always #4 pclk = ~pclk;

  gpio_port_model u_gpio_port_model (.pclk(pclk), .presetn(presetn),
    .go(go), .sel(sel), .port_access(port_access));

  sleep_port_clock_gating u_sleep_port_clock_gating (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_port_clock_gate(run_set),
    .deep_sleep_port_clock_gate(deep_set), .auto_gating_select(auto),
    .sleep_req(slp), .deep_sleep_req(deep), .port_access(port_access),
    .port_clk_en(port_clk_en), .port_fault(port_fault), .irq(irq));

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic access(input logic [2:0] p);
    @(posedge pclk);
    go <= 1;
    sel <= p;
    @(posedge pclk);
    go <= 0;
    f = 0;
    repeat (4) begin
      @(posedge pclk);
      f = f | port_fault;
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h118, '0);
    `CHK(rd, 32'h0)
    `CHK(port_clk_en, 8'h00)
    $display("test reset done");
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      `CHK(er, rows[i].e)
      apb(0, rows[i].a, '0);
      `CHK(rd, rows[i].q)
      `CHK(er, rows[i].e)
    end
    $display("test table done");
    run_set <= 8'h3c;
    deep_set <= 8'hc3;
    auto <= 1;
    slp <= 1;
    apb(0, 12'h118, '0);
    apb(1, 12'h118, (rd & 32'hffff_ff00) | 32'h0000_005a);
    settle();
    `CHK(port_clk_en, 8'h5a)
    apb(0, 12'h208, '0);
    `CHK(rd, 32'h5a)
    access(3'd0);
    `CHK(f, 1'b1)
    `CHK(irq, 1'b1)
    apb(0, 12'h200, '0);
    `CHK(rd, 32'h1)
    access(3'd1);
    `CHK(f, 1'b0)
    apb(1, 12'h200, 32'h1);
    apb(0, 12'h200, '0);
    `CHK(rd, 32'h0)
    `CHK(irq, 1'b0)
    access(3'd5);
    `CHK(f, 1'b1)
    `CHK(irq, 1'b0)
    apb(1, 12'h204, 32'hff);
    apb(0, 12'h200, '0);
    `CHK(rd, 32'h20)
    `CHK(irq, 1'b1)
    $display("test fault done");
    deep <= 1;
    settle();
    `CHK(port_clk_en, 8'hc3)
    auto <= 0;
    settle();
    `CHK(port_clk_en, 8'h3c)
    deep <= 0;
    slp <= 0;
    auto <= 1;
    settle();
    `CHK(port_clk_en, 8'h3c)
    apb(1, 12'h208, 32'hff);
    `CHK(er, 1'b1)
    $display("test modes done");
    ce <= 0;
    run_set <= 8'h81;
    settle();
    `CHK(port_clk_en, 8'h3c)
    ce <= 1;
    settle();
    `CHK(port_clk_en, 8'h81)
    $display("test enable done");
    @(posedge pclk);
    presetn <= 0;
    repeat (3) @(posedge pclk);
    `CHK(port_clk_en, 8'h00)
    `CHK(irq, 1'b0)
    presetn <= 1;
    apb(0, 12'h118, '0);
    `CHK(rd, 32'h0)
    apb(0, 12'h200, '0);
    `CHK(rd, 32'h0)
    $display("test mid reset done");
    complete_run();
  end
endmodule // tb_sleep_port_clock_gating
